//--- hdl/dcf_defs.vh
// constants for the dual-clock fifo flag block
// assumes inclusion by bare name from the design file
`ifndef DCF_DEFS_VH
`define DCF_DEFS_VH

`define DCF_DW          9
`define DCF_AW          14
`define DCF_CW          15
`define DCF_DEPTH       15'h4000
`define DCF_AE_OFS_RST  14'h007f
`define DCF_AF_OFS_RST  14'h007f
`define DCF_MODE_LOAD   1'b0
`define DCF_MODE_WEN2   1'b1

`endif

//--- hdl/dcf_fifo.v
// dual-clock fifo core with full, empty and almost flags
// assumes WCLK, RCLK and all pins are asynchronous to MCLK;
// MCLK must run well above both link clocks
// limitation: a link clock needs high and low phases of at least three
// MCLK periods, or its edges are lost in the synchroniser
// limitation: offsets load as one parallel strobe; no serial offset path
// trade-off: pins are synchronised, so every answer lags its pin by
// about three MCLK periods, in exchange for no metastable state
`timescale 1ns/10ps
`include "dcf_defs.vh"

module dcf_fifo (
    // clock and reset
    input  wire                   MCLK,
    input  wire                   RST_N,
    // write side
    input  wire                   WCLK,
    input  wire [`DCF_DW-1:0]     D,
    input  wire                   WR_EN_PRI_N,
    input  wire                   WR_EN_LOAD,
    input  wire [`DCF_AW-1:0]     AE_OFFSET,
    input  wire [`DCF_AW-1:0]     AF_OFFSET,
    output reg                    FULL_N,
    output reg                    ALMOST_FULL_N,
    // read side
    input  wire                   RCLK,
    input  wire                   RD_EN_PRI_N,
    input  wire                   RD_EN_SEC_N,
    input  wire                   OUT_EN_N,
    output reg  [`DCF_DW-1:0]     Q,
    output wire                   Q_OE,
    output reg                    EMPTY_N,
    output reg                    ALMOST_EMPTY_N,
    // configuration seen
    output reg                    LOAD_MODE
);

////////////////////////////////////////////////////////////////////////////
// two-stage synchronisers for every pin but RST_N and the offsets
localparam SW = 8 + `DCF_DW;

reg  [SW-1:0] s1_q;
reg  [SW-1:0] s2_q;
reg           wclk_d1_q;
reg           rclk_d1_q;

wire [SW-1:0] pins = {WCLK, RCLK, WR_EN_PRI_N, WR_EN_LOAD, RD_EN_PRI_N,
                      RD_EN_SEC_N, OUT_EN_N, 1'b0, D};

always @(posedge MCLK) begin
    s1_q <= pins;
    s2_q <= s1_q;
    wclk_d1_q <= s2_q[SW-1];
    rclk_d1_q <= s2_q[SW-2];
end

wire                wclk_s  = s2_q[SW-1];
wire                rclk_s  = s2_q[SW-2];
wire                write_enable_primary_n  = s2_q[SW-3];
wire                write_enable_or_load = s2_q[SW-4];
wire                read_enable_primary_n  = s2_q[SW-5];
wire                read_enable_secondary_n  = s2_q[SW-6];
wire                oe_n    = s2_q[SW-7];
wire [`DCF_DW-1:0]  din     = s2_q[`DCF_DW-1:0];

wire wr_edge = wclk_s & ~wclk_d1_q;
wire rd_edge = rclk_s & ~rclk_d1_q;

////////////////////////////////////////////////////////////////////////////
// offset pins are quasi-static but still cross into MCLK, so they get
// the same two stages as the other link pins before the load strobe reads
// them; a value changed less than two MCLK before the strobe is missed
reg [`DCF_AW-1:0] ae_ofs_s1_q;
reg [`DCF_AW-1:0] ae_ofs_s2_q;
reg [`DCF_AW-1:0] af_ofs_s1_q;
reg [`DCF_AW-1:0] af_ofs_s2_q;

always @(posedge MCLK) begin
    ae_ofs_s1_q <= AE_OFFSET;
    ae_ofs_s2_q <= ae_ofs_s1_q;
    af_ofs_s1_q <= AF_OFFSET;
    af_ofs_s2_q <= af_ofs_s1_q;
end

////////////////////////////////////////////////////////////////////////////
// storage, pointers and occupancy
reg [`DCF_DW-1:0] mem [0:(1<<`DCF_AW)-1];
reg [`DCF_AW-1:0] wptr_q;
reg [`DCF_AW-1:0] rptr_q;
reg [`DCF_CW-1:0] count_q;
reg [`DCF_AW-1:0] ae_ofs_q;
reg [`DCF_AW-1:0] af_ofs_q;

// WEN2 form: second enable only gates writes in that mode
wire wr_gate = (LOAD_MODE == `DCF_MODE_WEN2) ? write_enable_or_load : 1'b1;
wire ld_req  = wr_edge & (LOAD_MODE == `DCF_MODE_LOAD)
             & ~write_enable_or_load & ~write_enable_primary_n;
wire wr_ev   = wr_edge & ~write_enable_primary_n & wr_gate & ~ld_req
             & (count_q != `DCF_DEPTH);
// read only once empty flag already shows data
wire rd_ev   = rd_edge & ~read_enable_primary_n & ~read_enable_secondary_n & EMPTY_N
             & (count_q != {`DCF_CW{1'b0}});

reg [`DCF_CW-1:0] count_d;
always @* begin
    count_d = count_q;
    if (wr_ev && !rd_ev)
        count_d = count_q + 15'h0001;
    else if (rd_ev && !wr_ev)
        count_d = count_q - 15'h0001;
end

wire [`DCF_CW-1:0] af_thr = `DCF_DEPTH - {1'b0, af_ofs_q};

always @(posedge MCLK) begin
    if (wr_ev)
        mem[wptr_q] <= din;
end

////////////////////////////////////////////////////////////////////////////
// control state; reset is synchronous so running clocks are harmless
always @(posedge MCLK) begin
    if (!RST_N) begin
        wptr_q   <= {`DCF_AW{1'b0}};
        rptr_q   <= {`DCF_AW{1'b0}};
        count_q  <= {`DCF_CW{1'b0}};
        ae_ofs_q <= `DCF_AE_OFS_RST;
        af_ofs_q <= `DCF_AF_OFS_RST;
        // strap follows the pin for as long as reset is held;
        // the value on the last reset edge is kept, so the pin
        // need only be steady for the last few MCLK of reset
        LOAD_MODE <= write_enable_or_load;
    end else begin
        count_q <= count_d;
        if (wr_ev)
            wptr_q <= wptr_q + 14'h0001;
        if (rd_ev)
            rptr_q <= rptr_q + 14'h0001;
        if (ld_req) begin
            ae_ofs_q <= ae_ofs_s2_q;
            af_ofs_q <= af_ofs_s2_q;
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// next flag levels, all taken from the occupancy after this cycle's
// transfer so a flag never lags an event of its own side
reg full_n_d;
reg almost_full_n_d;
reg empty_n_d;
reg almost_empty_n_d;

always @* begin
    full_n_d         = (count_d != `DCF_DEPTH);
    almost_full_n_d  = (count_d < af_thr);
    empty_n_d        = (count_d != {`DCF_CW{1'b0}});
    almost_empty_n_d = (count_d > {1'b0, ae_ofs_q});
end

////////////////////////////////////////////////////////////////////////////
// write-side flags move only on write-clock edges
// skew minimum counts as met when the far edge fell in an earlier
// MCLK cycle or in the same one, since count_d holds both transfers;
// each flag still loads only on the edges of its own side's clock
always @(posedge MCLK) begin
    if (!RST_N) begin
        FULL_N        <= 1'b1;
        ALMOST_FULL_N <= 1'b1;
    end else if (wr_edge) begin
        // a read seen earlier releases full here
        FULL_N        <= full_n_d;
        ALMOST_FULL_N <= almost_full_n_d;
    end
end

// read-side flags move only on read-clock edges
always @(posedge MCLK) begin
    if (!RST_N) begin
        EMPTY_N        <= 1'b0;
        ALMOST_EMPTY_N <= 1'b0;
    end else if (rd_edge) begin
        // a write seen earlier releases empty here
        EMPTY_N        <= empty_n_d;
        ALMOST_EMPTY_N <= almost_empty_n_d;
    end
end

////////////////////////////////////////////////////////////////////////////
// read data: word leaves on the first read edge after empty rises
// reads are gated by the registered empty flag as well as the count, so a
// word is never shown before the reader could have seen empty rise
always @(posedge MCLK) begin
    if (!RST_N)
        Q <= {`DCF_DW{1'b0}};
    else if (rd_ev)
        Q <= mem[rptr_q];
end

assign Q_OE = ~oe_n;

endmodule

//--- verif/dcf_chk_sva.sv
// checker: flag, data and strap relations of the fifo core
// assumes bind onto dcf_fifo; everything sampled on MCLK
`timescale 1ns/10ps
module dcf_chk (
    input wire       MCLK, RST_N, WCLK, RCLK, WR_EN_LOAD, OUT_EN_N,
    input wire       RD_EN_PRI_N, RD_EN_SEC_N, FULL_N, ALMOST_FULL_N,
    input wire       EMPTY_N, ALMOST_EMPTY_N, Q_OE, LOAD_MODE,
    input wire [8:0] Q
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    AST_EMPTY_AE: assert property (!EMPTY_N |-> !ALMOST_EMPTY_N)
        else $error("empty but not almost empty");
    AST_OE: assert property (
        $stable(OUT_EN_N)[*5] |-> Q_OE == !OUT_EN_N) else $error("bad drive");
    AST_Q_EMPTY: assert property (
        $changed(Q) |-> $past(EMPTY_N) || $past(EMPTY_N, 2))
        else $error("data moved while empty");
    AST_Q_EN: assert property (
        $changed(Q) |-> !$past(RD_EN_PRI_N, 3) && !$past(RD_EN_SEC_N, 3))
        else $error("data moved without both enables");
    AST_STRAP: assert property (
        $rose(RST_N) |-> LOAD_MODE == $past(WR_EN_LOAD, 3))
        else $error("strap not taken");
    AST_HOLD: assert property ($past(RST_N) |-> $stable(LOAD_MODE))
        else $error("mode moved after reset");
    // slack of two samples covers the pin synchroniser
    AST_RSIDE: assert property (
        $changed(EMPTY_N) || $changed(ALMOST_EMPTY_N)
        |-> $past(RCLK, 2) || $past(RCLK, 3)) else $error("read flag off");
    AST_WSIDE: assert property (
        $changed(FULL_N) || $changed(ALMOST_FULL_N)
        |-> $past(WCLK, 2) || $past(WCLK, 3)) else $error("write flag off");
    cover property ($rose(EMPTY_N));
    cover property ($fell(ALMOST_FULL_N));
    cover property ($rose(RST_N) && !LOAD_MODE);
endmodule

//--- verif/dcf_link.sv
// partner: free running write and read link clocks, 64 ns
// assumes the bench drives enables against these edges
`timescale 1ns/10ps
module dcf_link (
    output reg wclk,
    output reg rclk
);
    // offset phase keeps read and write edges apart
    initial begin
        wclk = 0;
        rclk = 0;
        fork
            forever #32 wclk = ~wclk;
            #13 forever #32 rclk = ~rclk;
        join
    end
endmodule

//--- verif/testbench.sv
// bench: writer and reader tasks against the fifo core
// assumes dcf_link makes the link clocks; checker bound below
`timescale 1ns/10ps
module testbench;
    reg         MCLK = 0, RST_N = 0, wp_n = 1, wl = 1;
    reg         rp_n = 1, rs_n = 1, oe_n = 0;
    reg  [8:0]  d = 9'h000;
    reg  [13:0] ae = 14'h0000, af = 14'h0000;
    wire        wclk, rclk, ff_n, af_n, ef_n, ae_n, q_oe, mode;
    wire [8:0]  q;
    integer     n_errors = 0, tests_run = 0, i;
    initial forever #2.5 MCLK = ~MCLK;
    dcf_link i_dcf_link (.wclk(wclk), .rclk(rclk));
    dcf_fifo i_dcf_fifo (.MCLK(MCLK), .RST_N(RST_N), .WCLK(wclk), .D(d),
        .WR_EN_PRI_N(wp_n), .WR_EN_LOAD(wl), .AE_OFFSET(ae),
        .AF_OFFSET(af), .FULL_N(ff_n), .ALMOST_FULL_N(af_n), .RCLK(rclk),
        .RD_EN_PRI_N(rp_n), .RD_EN_SEC_N(rs_n), .OUT_EN_N(oe_n), .Q(q),
        .Q_OE(q_oe), .EMPTY_N(ef_n), .ALMOST_EMPTY_N(ae_n),
        .LOAD_MODE(mode));
    task chk(input string nm, input [15:0] s, e);
        tests_run++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED %s exp %h seen %h", nm, e, s);
        end
    endtask
    // set in the low half, hold past the synchronised edge
    task wr(input [8:0] v, input l);
        @(negedge wclk); @(posedge MCLK); d <= v; wp_n <= 0; wl <= l;
        @(posedge wclk); repeat (6) @(posedge MCLK); wp_n <= 1; wl <= 1;
    endtask
    task rd(input s);
        @(negedge rclk); @(posedge MCLK); rp_n <= 0; rs_n <= s;
        @(posedge rclk); repeat (6) @(posedge MCLK); rp_n <= 1; rs_n <= 1;
    endtask
    task st;
        repeat (2) @(posedge rclk); repeat (2) @(posedge wclk);
        repeat (6) @(posedge MCLK);
    endtask
    task rst(input l);
        @(posedge MCLK); RST_N <= 0; wl <= l;
        repeat (10) @(posedge MCLK); RST_N <= 1;
        repeat (3) @(posedge MCLK);
    endtask
    task close_out;
        if (n_errors == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        #200000 n_errors++;
        close_out;
    end
    initial begin
        rst(1);
        chk("mode", mode, 1); chk("ef", ef_n, 0);
        chk("ff", ff_n, 1); chk("qoe", q_oe, 1); chk("q", q, 0);
        rd(0); st; chk("rd empty", q, 0);
        wr(9'h1a5, 0); st; chk("wen2 low", ef_n, 0);
        wr(9'h1a5, 1); st; chk("ef up", ef_n, 1);
        rd(1); chk("one enable", q, 0);
        rd(0); chk("first", q, 9'h1a5);
        for (i = 0; i < 127; i++) wr(i[8:0], 1);
        st; chk("ae at ofs", ae_n, 0);
        wr(9'h07f, 1); st; chk("ae above", ae_n, 1);
        rd(0); st; chk("ae back", ae_n, 0); chk("q0", q, 0);
        oe_n <= 1; repeat (6) @(posedge MCLK); chk("hiz", q_oe, 0);
        rst(0); chk("mode0", mode, 0); chk("ef rst", ef_n, 0);
        ae <= 14'h0002; af <= 14'h3ffc; wr(9'h000, 0);
        for (i = 1; i < 5; i++) begin
            wr(i[8:0], 1); chk("af", af_n, i < 4);
        end
        st; chk("ae ofs2", ae_n, 1);
        rd(0); st; chk("af off", af_n, 1); chk("q1", q, 1);
        close_out;
    end
endmodule
bind dcf_fifo dcf_chk i_dcf_chk (.*);
